// ==== rtl/gds_pkg.sv ====
// Purpose: Shared constants for the GPIO data, set and clear block
// Assumes: APB word registers, 88 pins split over ports A, B and C
// Notes: Offsets are byte addresses on the APB bus
package gds_pkg;
    // ----------------------------------------
    // Widths and pin map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_N = 88;
    localparam int PORT_A_W = 32;
    localparam int PORT_B_W = 32;
    localparam int PORT_C_W = 24;
    localparam int PORT_B_BASE = 32;
    localparam int PORT_C_BASE = 64;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_B_DATA = 8'h00;
    localparam logic [7:0] OFF_C_DATA = 8'h04;
    localparam logic [7:0] OFF_A_SET = 8'h08;
    localparam logic [7:0] OFF_A_CLR = 8'h0C;
    localparam logic [7:0] OFF_A_INV = 8'h10;
    localparam logic [7:0] OFF_A_FSEL = 8'h14;
    localparam logic [7:0] OFF_A_DIR = 8'h18;
    localparam logic [7:0] OFF_B_FSEL = 8'h1C;
    localparam logic [7:0] OFF_B_DIR = 8'h20;
    localparam logic [7:0] OFF_C_FSEL = 8'h24;
    localparam logic [7:0] OFF_C_DIR = 8'h28;
    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_C_PAD = 8'h00;
endpackage : gds_pkg

// ==== rtl/gds_reg_if.sv ====
// Purpose: Decoded register access between APB front and core
// Assumes: One access at a time
// Notes: Front drives strobes, core answers with data and hit
`timescale 1ns/1ps
interface gds_reg_if;
    import gds_pkg::*;
    logic wr_en; // Write taken this cycle
    logic rd_cap; // Read setup cycle
    logic [ADDR_W-1:0] addr; // Byte address
    logic [DATA_W-1:0] wdata; // Write data
    logic [DATA_W-1:0] rdata; // Read data from core
    logic hit; // Address is mapped
    modport front (output wr_en, rd_cap, addr, wdata, input rdata, hit);
    modport core (input wr_en, rd_cap, addr, wdata, output rdata, hit);
endinterface : gds_reg_if

// ==== rtl/gds_apb_front.sv ====
// Purpose: APB slave front end, zero wait states
// Assumes: APB3 signalling, one clock
// Notes: Read data is captured in the setup cycle
`timescale 1ns/1ps
module gds_apb_front
    import gds_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gds_pkg::ADDR_W-1:0] paddr,
    input wire logic [gds_pkg::DATA_W-1:0] pwdata,
    output logic [gds_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    gds_reg_if.front rif
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] rdata; // Captured read word
    } gds_front_st_t;
    gds_front_st_t st;
    gds_front_st_t next_st;

    // Strobes toward the core
    assign rif.addr = paddr;
    assign rif.wdata = pwdata;
    assign rif.rd_cap = psel & ~penable & ~pwrite;
    assign rif.wr_en = psel & penable & pwrite & rif.hit;
    // Never waits; unmapped access answers with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rif.hit;
    assign prdata = st.rdata;

    // Read capture
    always_comb
    begin
        next_st = st;
        if (rif.rd_cap)
        begin
            next_st.rdata = rif.rdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule : gds_apb_front

// ==== rtl/gds_latch_bank.sv ====
// Purpose: Output latch bank for one port
// Assumes: At most one strobe per cycle
// Notes: Pad enable is active low
`timescale 1ns/1ps
module gds_latch_bank #(
    parameter int W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load_en,
    input wire logic set_en,
    input wire logic clr_en,
    input wire logic inv_en,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] drive_en,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n
);
    import gds_pkg::*;
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [W-1:0] latch; // Output latch
    } gds_bank_st_t;
    gds_bank_st_t st;
    gds_bank_st_t next_st;

    assign pin_out = st.latch; // see R2
    assign pin_oe_n = ~drive_en; // see R13

    // Latch update; zero bits of set/clear/invert words change nothing
    always_comb
    begin
        next_st = st;
        if (load_en)
        begin
            next_st.latch = wdata; // see R2
        end
        else if (set_en)
        begin
            next_st.latch = st.latch | wdata; // see R6 see R8
        end
        else if (clr_en)
        begin
            next_st.latch = st.latch & ~wdata; // see R7 see R8
        end
        else if (inv_en)
        begin
            next_st.latch = st.latch ^ wdata; // see R12
        end
    end

    // Latch register, cleared by reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0; // see R11
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_load;
        @(posedge pclk) disable iff (!presetn) load_en |=> pin_out == $past(wdata);
    endproperty
    a_load: assert property (p_load) else $error("latch load wrong"); // see R2
    property p_set;
        @(posedge pclk) disable iff (!presetn)
            set_en && !load_en |=> pin_out == ($past(pin_out) | $past(wdata));
    endproperty
    a_set: assert property (p_set) else $error("latch set wrong"); // see R6
    property p_clr;
        @(posedge pclk) disable iff (!presetn)
            clr_en && !load_en && !set_en |=> pin_out == ($past(pin_out) & ~$past(wdata));
    endproperty
    a_clr: assert property (p_clr) else $error("latch clear wrong"); // see R7
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
            !(load_en || set_en || clr_en || inv_en) |=> $stable(pin_out);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without write"); // see R11
    property p_inv;
        @(posedge pclk) disable iff (!presetn)
            inv_en && !load_en && !set_en && !clr_en |=> pin_out == ($past(pin_out) ^ $past(wdata));
    endproperty
    a_inv: assert property (p_inv) else $error("latch invert wrong"); // see R12
endmodule : gds_latch_bank

// ==== rtl/gds_top.sv ====
// Purpose: GPIO data, set and clear registers with pad control
// Assumes: Pin inputs already qualified and synchronous to pclk
// Notes: Pins 0-31 port A, 32-63 port B, 64-87 port C
`timescale 1ns/1ps

// Contract
// R1 - Data read returns pin level, any function
// R2 - Data write stores latch; drives if GPIO output
// R3 - Port B bit n is pin n+32
// R4 - Port C bits 23-0; upper bits zero
// R5 - Data read after reset follows pins
// R6 - Set writes force latch bits high
// R7 - Clear writes force latch bits low
// R8 - Zero bits in set/clear change nothing
// R9 - Set and clear registers read zero
// R10 - Set/clear bit n is pin n; reset zero
// R11 - Latch holds until written; reset clears
// R12 - Invert writes toggle port A latch bits
// R13 - Pad driven only when GPIO and output
module gds_top
    import gds_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gds_pkg::ADDR_W-1:0] paddr,
    input wire logic [gds_pkg::DATA_W-1:0] pwdata,
    output logic [gds_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gds_pkg::PIN_N-1:0] pin_in,
    output logic [gds_pkg::PIN_N-1:0] pin_out,
    output logic [gds_pkg::PIN_N-1:0] pin_oe_n
);
    import gds_pkg::*;

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    // Function select bit: 0 picks GPIO, 1 a peripheral
    // Direction bit: 1 picks output
    typedef struct packed {
        logic [PORT_A_W-1:0] fsel_a; // Port A function select
        logic [PORT_A_W-1:0] dir_a; // Port A direction
        logic [PORT_B_W-1:0] fsel_b; // Port B function select
        logic [PORT_B_W-1:0] dir_b; // Port B direction
        logic [PORT_C_W-1:0] fsel_c; // Port C function select
        logic [PORT_C_W-1:0] dir_c; // Port C direction
    } gds_cfg_st_t;
    gds_cfg_st_t st; // Registered configuration
    gds_cfg_st_t next_st; // Next configuration

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    gds_reg_if rif (); // Decoded access
    logic [PORT_A_W-1:0] pins_a; // Port A pin levels
    logic [PORT_B_W-1:0] pins_b; // Port B pin levels
    logic [PORT_C_W-1:0] pins_c; // Port C pin levels
    logic [PORT_A_W-1:0] drive_a; // Port A GPIO output
    logic [PORT_B_W-1:0] drive_b; // Port B GPIO output
    logic [PORT_C_W-1:0] drive_c; // Port C GPIO output
    logic load_b; // Port B data write
    logic load_c; // Port C data write
    logic set_a; // Port A set write
    logic clr_a; // Port A clear write
    logic inv_a; // Port A invert write
    logic [DATA_W-1:0] rd_word; // Read mux result
    logic rd_hit; // Address decodes

    // ----------------------------------------
    // APB front end
    // ----------------------------------------
    gds_apb_front u_front (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.front)
    );

    // ----------------------------------------
    // Pin slices
    // ----------------------------------------
    // Port B pins 63-32 sit on bits 31-0
    assign pins_a = pin_in[PORT_A_W-1:0];
    assign pins_b = pin_in[PORT_B_BASE+PORT_B_W-1:PORT_B_BASE]; // see R3
    assign pins_c = pin_in[PORT_C_BASE+PORT_C_W-1:PORT_C_BASE]; // see R4

    // GPIO output only when function is GPIO and direction is output
    assign drive_a = ~st.fsel_a & st.dir_a; // see R13
    assign drive_b = ~st.fsel_b & st.dir_b; // see R13
    assign drive_c = ~st.fsel_c & st.dir_c; // see R13

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    assign load_b = rif.wr_en && (rif.addr == OFF_B_DATA); // see R2
    assign load_c = rif.wr_en && (rif.addr == OFF_C_DATA); // see R2
    assign set_a = rif.wr_en && (rif.addr == OFF_A_SET); // see R6 see R10
    assign clr_a = rif.wr_en && (rif.addr == OFF_A_CLR); // see R7 see R10
    assign inv_a = rif.wr_en && (rif.addr == OFF_A_INV); // see R12

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Data reads show pins, never the latch; unmapped reads give zero
    always_comb
    begin
        rd_word = RST_WORD;
        rd_hit = 1'b1;
        if (rif.addr == OFF_B_DATA)
        begin
            rd_word = pins_b; // see R1 see R3 see R5
        end
        else if (rif.addr == OFF_C_DATA)
        begin
            rd_word = {RST_C_PAD, pins_c}; // see R1 see R4 see R5
        end
        else if (rif.addr == OFF_A_SET || rif.addr == OFF_A_CLR || rif.addr == OFF_A_INV)
        begin
            rd_word = RST_WORD; // see R9
        end
        else if (rif.addr == OFF_A_FSEL)
        begin
            rd_word = st.fsel_a;
        end
        else if (rif.addr == OFF_A_DIR)
        begin
            rd_word = st.dir_a;
        end
        else if (rif.addr == OFF_B_FSEL)
        begin
            rd_word = st.fsel_b;
        end
        else if (rif.addr == OFF_B_DIR)
        begin
            rd_word = st.dir_b;
        end
        else if (rif.addr == OFF_C_FSEL)
        begin
            rd_word = {RST_C_PAD, st.fsel_c};
        end
        else if (rif.addr == OFF_C_DIR)
        begin
            rd_word = {RST_C_PAD, st.dir_c};
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    assign rif.rdata = rd_word;
    assign rif.hit = rd_hit;

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        if (rif.wr_en)
        begin
            if (rif.addr == OFF_A_FSEL)
            begin
                next_st.fsel_a = rif.wdata;
            end
            else if (rif.addr == OFF_A_DIR)
            begin
                next_st.dir_a = rif.wdata;
            end
            else if (rif.addr == OFF_B_FSEL)
            begin
                next_st.fsel_b = rif.wdata;
            end
            else if (rif.addr == OFF_B_DIR)
            begin
                next_st.dir_b = rif.wdata;
            end
            else if (rif.addr == OFF_C_FSEL)
            begin
                next_st.fsel_c = rif.wdata[PORT_C_W-1:0];
            end
            else if (rif.addr == OFF_C_DIR)
            begin
                next_st.dir_c = rif.wdata[PORT_C_W-1:0];
            end
        end
    end

    // Configuration register; all pins start as GPIO inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Latch banks
    // ----------------------------------------
    // Port A: set, clear and invert only
    gds_latch_bank #(.W(PORT_A_W)) u_bank_a (
        .pclk(pclk),
        .presetn(presetn),
        .load_en(1'b0),
        .set_en(set_a),
        .clr_en(clr_a),
        .inv_en(inv_a),
        .wdata(rif.wdata),
        .drive_en(drive_a),
        .pin_out(pin_out[PORT_A_W-1:0]),
        .pin_oe_n(pin_oe_n[PORT_A_W-1:0])
    );

    // Port B: whole-word data writes
    gds_latch_bank #(.W(PORT_B_W)) u_bank_b (
        .pclk(pclk),
        .presetn(presetn),
        .load_en(load_b),
        .set_en(1'b0),
        .clr_en(1'b0),
        .inv_en(1'b0),
        .wdata(rif.wdata),
        .drive_en(drive_b),
        .pin_out(pin_out[PORT_B_BASE+PORT_B_W-1:PORT_B_BASE]),
        .pin_oe_n(pin_oe_n[PORT_B_BASE+PORT_B_W-1:PORT_B_BASE])
    );

    // Port C: low 24 bits of data writes
    gds_latch_bank #(.W(PORT_C_W)) u_bank_c (
        .pclk(pclk),
        .presetn(presetn),
        .load_en(load_c),
        .set_en(1'b0),
        .clr_en(1'b0),
        .inv_en(1'b0),
        .wdata(rif.wdata[PORT_C_W-1:0]),
        .drive_en(drive_c),
        .pin_out(pin_out[PORT_C_BASE+PORT_C_W-1:PORT_C_BASE]),
        .pin_oe_n(pin_oe_n[PORT_C_BASE+PORT_C_W-1:PORT_C_BASE])
    );

    // ----------------------------------------
    // Checks: register reads
    // ----------------------------------------
    // Port B read shows the pins seen at setup
    property p_b_read;
        @(posedge pclk) disable iff (!presetn)
            rif.rd_cap && rif.addr == OFF_B_DATA |=> prdata == $past(pin_in[63:32]);
    endproperty
    a_b_read: assert property (p_b_read) else $error("port B read not pins"); // see R3
    // Port C read shows 24 pins, upper byte zero
    property p_c_read;
        @(posedge pclk) disable iff (!presetn)
            rif.rd_cap && rif.addr == OFF_C_DATA |=> prdata == {8'h00, $past(pin_in[87:64])};
    endproperty
    a_c_read: assert property (p_c_read) else $error("port C read wrong"); // see R4
    // Set and clear registers read back zero
    property p_sc_zero;
        @(posedge pclk) disable iff (!presetn)
            rif.rd_cap && (rif.addr == OFF_A_SET || rif.addr == OFF_A_CLR) |=> prdata == 32'h0000_0000;
    endproperty
    a_sc_zero: assert property (p_sc_zero) else $error("set or clear read nonzero"); // see R9
    // Invert register reads back zero
    property p_inv_zero;
        @(posedge pclk) disable iff (!presetn)
            rif.rd_cap && rif.addr == OFF_A_INV |=> prdata == 32'h0000_0000;
    endproperty
    a_inv_zero: assert property (p_inv_zero) else $error("invert read nonzero"); // see R12
    // Read data holds until the next read setup
    property p_read_hold;
        @(posedge pclk) disable iff (!presetn)
            !rif.rd_cap |=> $stable(prdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved without read"); // see R1
    // Port C configuration reads keep the upper byte zero
    property p_c_cfg_upper;
        @(posedge pclk) disable iff (!presetn)
            rif.rd_cap && (rif.addr == OFF_C_FSEL || rif.addr == OFF_C_DIR) |=> prdata[31:24] == 8'h00;
    endproperty
    a_c_cfg_upper: assert property (p_c_cfg_upper) else $error("port C config upper bits set"); // see R4

    // ----------------------------------------
    // Checks: latch writes
    // ----------------------------------------
    // Every set bit on a driven pin shows high and driven
    property p_set_pin;
        @(posedge pclk) disable iff (!presetn)
            set_a |=> ((pin_out[31:0] & ~pin_oe_n[31:0]) & $past(rif.wdata)) == ($past(rif.wdata) & drive_a);
    endproperty
    a_set_pin: assert property (p_set_pin) else $error("set bit not driven high"); // see R6
    // Every cleared bit on a driven pin shows low and driven
    property p_clr_pin;
        @(posedge pclk) disable iff (!presetn)
            clr_a |=> ((~pin_out[31:0] & ~pin_oe_n[31:0]) & $past(rif.wdata)) == ($past(rif.wdata) & drive_a);
    endproperty
    a_clr_pin: assert property (p_clr_pin) else $error("clear bit not driven low"); // see R7
    // Invert flips exactly the written bits
    property p_inv_pin;
        @(posedge pclk) disable iff (!presetn)
            inv_a |=> pin_out[31:0] == ($past(pin_out[31:0]) ^ $past(rif.wdata));
    endproperty
    a_inv_pin: assert property (p_inv_pin) else $error("invert did not toggle latch"); // see R12
    // Port B data write lands in the latch
    property p_b_load;
        @(posedge pclk) disable iff (!presetn)
            load_b |=> pin_out[63:32] == $past(rif.wdata);
    endproperty
    a_b_load: assert property (p_b_load) else $error("port B latch not loaded"); // see R2
    // Port C data write lands in the low 24 latch bits
    property p_c_load;
        @(posedge pclk) disable iff (!presetn)
            load_c |=> pin_out[87:64] == $past(rif.wdata[23:0]);
    endproperty
    a_c_load: assert property (p_c_load) else $error("port C latch not loaded"); // see R4
    // An unmapped write leaves every latch alone
    property p_unmapped_hold;
        @(posedge pclk) disable iff (!presetn)
            psel && penable && pwrite && !rif.hit |=> $stable(pin_out);
    endproperty
    a_unmapped_hold: assert property (p_unmapped_hold) else $error("unmapped write moved a latch"); // see R11

    // ----------------------------------------
    // Checks: reset
    // ----------------------------------------
    // Latches clear and pads release on reset
    property p_reset_out;
        @(posedge pclk) disable iff (!presetn)
            $rose(presetn) |-> pin_out == {PIN_N{1'b0}} && pin_oe_n == {PIN_N{1'b1}};
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset"); // see R11
endmodule : gds_top

// ==== tb/gds_top_bench.sv ====
// Purpose: Self-checking bench for the GPIO data, set and clear block
// Assumes: Zero-wait APB slave, pin inputs synchronous to pclk
// Notes: Expected latch and pad values are kept in exp_out and exp_oe
`timescale 1ns/1ps
module gds_top_bench;
    import gds_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk; // Bus clock
    logic presetn; // Async reset
    logic psel; // APB select
    logic penable; // APB access phase
    logic pwrite; // APB direction
    logic [ADDR_W-1:0] paddr; // APB address
    logic [DATA_W-1:0] pwdata; // APB write data
    logic [DATA_W-1:0] prdata; // APB read data
    logic pready; // APB ready
    logic pslverr; // APB error
    logic [PIN_N-1:0] pin_in; // Pin levels
    logic [PIN_N-1:0] pin_out; // Latch values
    logic [PIN_N-1:0] pin_oe_n; // Pad enables
    logic [PIN_N-1:0] exp_out; // Expected latches
    logic [PIN_N-1:0] exp_oe; // Expected pad enables
    logic [DATA_W-1:0] rd_word; // Last read data
    logic rd_err; // Last error flag
    int err_count; // Mismatches
    int comparisons; // Comparisons made

    gds_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    // Clock at 40 MHz
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // One APB transfer, entered just after a rising edge; psel left up
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            err_count++;
            $display("mismatch pready expected 1 seen %b", pready);
            tally_and_finish();
        end
        else
        begin
            rd_word = prdata;
            rd_err = pslverr;
            penable <= 1'b0;
        end
    endtask : xfer

    // Single write or read, then one idle cycle
    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        xfer(1'b1, addr, wd);
        psel <= 1'b0;
        @(posedge pclk);
    endtask : wr

    task automatic rd(input logic [7:0] addr);
        xfer(1'b0, addr, 32'h0000_0000);
        psel <= 1'b0;
        @(posedge pclk);
    endtask : rd

    // Compare pads mid-cycle, return just after an edge
    task automatic pins();
        @(negedge pclk);
        check("pin_out", pin_out, exp_out);
        check("pin_oe_n", pin_oe_n, exp_oe);
        @(posedge pclk);
    endtask : pins

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_after_reset();
        pins();
        rd(OFF_B_DATA);
        check("port b data", rd_word, 32'h1234_5678);
        rd(OFF_A_SET);
        check("set reset", rd_word, 32'h0000_0000);
        rd(OFF_A_CLR);
        check("clear reset", rd_word, 32'h0000_0000);
        $display("test after_reset done");
    endtask : t_after_reset

    task automatic t_data_read();
        rd(OFF_C_DATA);
        check("port c data", rd_word, 32'h00C3_0F5A);
        pin_in <= {24'hFFFFFF, 32'hFFFF_0000, 32'h0000_0000};
        @(posedge pclk);
        rd(OFF_B_DATA);
        check("port b data", rd_word, 32'hFFFF_0000);
        rd(OFF_C_DATA);
        check("port c data", rd_word, 32'h00FF_FFFF);
        $display("test data_read done");
    endtask : t_data_read

    task automatic t_data_write();
        wr(OFF_B_DATA, 32'hA5A5_3C3C);
        wr(OFF_C_DATA, 32'hFF12_3456);
        exp_out = {24'h123456, 32'hA5A5_3C3C, 32'h0000_0000};
        pins();
        rd(OFF_B_DATA);
        check("port b pins not latch", rd_word, 32'hFFFF_0000);
        $display("test data_write done");
    endtask : t_data_write

    task automatic t_drive();
        wr(OFF_A_DIR, 32'h0000_FFFF);
        wr(OFF_B_DIR, 32'hFFFF_FFFF);
        wr(OFF_C_DIR, 32'hFFFF_FFFF);
        wr(OFF_A_FSEL, 32'h0000_00FF);
        wr(OFF_C_FSEL, 32'h0000_0001);
        exp_oe = {24'h000001, 32'h0000_0000, 32'hFFFF_00FF};
        pins();
        rd(OFF_C_DIR);
        check("port c direction", rd_word, 32'h00FF_FFFF);
        $display("test drive done");
    endtask : t_drive

    task automatic t_set_clear();
        // Back-to-back set then clear
        xfer(1'b1, OFF_A_SET, 32'h8000_0FF1);
        xfer(1'b1, OFF_A_CLR, 32'h0000_0111);
        psel <= 1'b0;
        @(posedge pclk);
        exp_out[31:0] = 32'h8000_0EE0;
        pins();
        wr(OFF_A_SET, 32'h0000_0000);
        wr(OFF_A_CLR, 32'h0000_0000);
        pins();
        rd(OFF_A_SET);
        check("set read", rd_word, 32'h0000_0000);
        check("set read error", rd_err, 1'b0);
        rd(OFF_A_CLR);
        check("clear read", rd_word, 32'h0000_0000);
        $display("test set_clear done");
    endtask : t_set_clear

    task automatic t_invert();
        wr(OFF_A_INV, 32'h0000_0F11);
        exp_out[31:0] = 32'h8000_01F1;
        pins();
        rd(OFF_A_INV);
        check("invert read", rd_word, 32'h0000_0000);
        $display("test invert done");
    endtask : t_invert

    task automatic t_unmapped();
        wr(8'h40, 32'hFFFF_FFFF);
        check("unmapped write error", rd_err, 1'b1);
        pins();
        rd(8'h40);
        check("unmapped read", rd_word, 32'h0000_0000);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_mid_reset();
        presetn <= 1'b0;
        exp_out = '0;
        exp_oe = '1;
        repeat (2) @(posedge pclk);
        pins();
        presetn <= 1'b1;
        pin_in <= {24'h00000F, 32'h0F0F_0F0F, 32'h0000_0000};
        @(posedge pclk);
        pins();
        rd(OFF_B_DATA);
        check("port b after reset", rd_word, 32'h0F0F_0F0F);
        $display("test mid_reset done");
    endtask : t_mid_reset

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        err_count = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pin_in = {24'hC30F5A, 32'h1234_5678, 32'h9ABC_DEF0};
        exp_out = '0;
        exp_oe = '1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_after_reset();
        t_data_read();
        t_data_write();
        t_drive();
        t_set_clear();
        t_invert();
        t_unmapped();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : gds_top_bench
